// ==== core/bro_output_mux.sv ====
`timescale 1ns/1ps
// What this block does
// [RQ1] select low shows the error word, select high shows the data byte.
// [RQ2] bus driven only while output enable is high, else high impedance.
// [RQ3] eight-bit three-state bus, seven bits shared between data and errors.
// [RQ4] error bit 1: new byte while holding and shift registers both full.
// [RQ5] error bit 2: odd parity over data and sync bit.
// [RQ6] error bit 3: set whenever error bit 2, 4 or 5 is set.
// [RQ7] error bit 4: ending sequence malformed.
// [RQ8] error bit 5: mid-bit transition lost outside the ending sequence.
// [RQ9] error bit 6: new start while holding register still unread.
// [RQ10] error bit 7: receiver disabled while a message is active.
// [RQ11] serial data and shift clock into the shift register copied out.
// [RQ12] error flag drops after an error-word read or a new valid start.
// [RQ13] any error raises error flag, drops receiver active and byte available.
// [RQ14] on read strobe rising, pending shift byte moves to holding register.
// [RQ15] spare bus bit reads low in error mode.
module bro_output_mux (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire bro_pkg::bro_pins_t pins_i,
	input  wire bro_pkg::bro_ev_t ev_i,
	input  wire logic [7:0]       rx_byte_i,
	input  wire logic             ser_bit_i,
	input  wire logic             ser_shift_i,
	output logic      [7:0]       data_o,
	output logic                  data_oe,
	output logic                  error_o,
	output logic                  rx_active_o,
	output logic                  byte_avail_o,
	output logic                  ser_data_o,
	output logic                  ser_clk_o
);
	import bro_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// three stages; filtered value moves only when stages two and three agree
	logic [BRO_PIN_W-1:0] s1_q, s2_q, s3_q, filt_q;
	logic [BRO_PIN_W-1:0] s1_d, s2_d, s3_d, filt_d;
	logic [BRO_PIN_W-1:0] agree;
	bro_pins_t            pin;

	always_comb begin
		s1_d   = pins_i;
		s2_d   = s1_q;
		s3_d   = s2_q;
		agree  = ~(s2_q ^ s3_q);
		filt_d = (filt_q & ~agree) | (s3_q & agree);
		pin    = filt_q;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_q   <= BRO_PINS_RST;
			s2_q   <= BRO_PINS_RST;
			s3_q   <= BRO_PINS_RST;
			filt_q <= BRO_PINS_RST;
		end else begin
			s1_q   <= s1_d;
			s2_q   <= s2_d;
			s3_q   <= s3_d;
			filt_q <= filt_d;
		end
	end

	// ------------------------------------------------------------
	// read strobe edge
	// ------------------------------------------------------------
	logic read_prev_q, read_prev_d;
	logic read_rise;
	logic read_data_done;
	logic read_err_done;

	always_comb begin
		read_prev_d    = pin.read_n;
		read_rise      = pin.read_n && !read_prev_q;
		read_data_done = read_rise && pin.sel;
		read_err_done  = read_rise && !pin.sel;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			read_prev_q <= 1'b1;
		end else begin
			read_prev_q <= read_prev_d;
		end
	end

	// ------------------------------------------------------------
	// error capture
	// ------------------------------------------------------------
	logic [7:1] err_q, err_d;
	logic [7:1] err_set;
	logic       err_clr;
	logic       any_err_set;
	logic       rx_active_q, rx_active_d;
	logic       hold_full_q, hold_full_d;
	logic       pend_full_q, pend_full_d;
	logic       xfer_q, xfer_d;
	logic       overflow;

	// a byte landing while the previous pending byte is being moved is
	// not an overflow: the move frees the pending slot in that cycle
	assign overflow = ev_i.byte_done && hold_full_q && pend_full_q && !xfer_q;  // see [RQ4]

	always_comb begin
		err_set                   = '0;
		err_set[BRO_ERR_OVERFLOW] = overflow;                            // see [RQ4]
		err_set[BRO_ERR_PARITY]   = ev_i.parity_bad;                     // see [RQ5]
		err_set[BRO_ERR_BAD_END]  = ev_i.end_bad;                        // see [RQ7]
		err_set[BRO_ERR_LOST_MID] = ev_i.mid_lost;                       // see [RQ8]
		err_set[BRO_ERR_RESTART]  = ev_i.start_ok && hold_full_q;        // see [RQ9]
		err_set[BRO_ERR_DISABLED] = pin.rx_dis && rx_active_q;           // see [RQ10]
		any_err_set               = |err_set;
		err_clr                   = read_err_done || ev_i.start_ok;      // see [RQ12]
		// set wins over clear
		err_d                     = (err_q & ~{7{err_clr}}) | err_set;
		err_d[BRO_ERR_SUMMARY]    = err_d[BRO_ERR_PARITY] | err_d[BRO_ERR_BAD_END]
		                          | err_d[BRO_ERR_LOST_MID];              // see [RQ6]
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			err_q <= BRO_ERR_RST;
		end else begin
			err_q <= err_d;
		end
	end

	// ------------------------------------------------------------
	// message state and byte registers
	// ------------------------------------------------------------
	logic [7:0] hold_q, hold_d;
	logic [7:0] pend_q, pend_d;

	always_comb begin
		// an error ends the message at once
		rx_active_d = (rx_active_q || ev_i.start_ok) && !ev_i.end_ok
		              && !any_err_set;                                   // see [RQ13]
		hold_d      = hold_q;
		pend_d      = pend_q;
		hold_full_d = hold_full_q;
		pend_full_d = pend_full_q;
		xfer_d      = 1'b0;
		if (xfer_q) begin
			hold_d      = pend_q;                                        // see [RQ14]
			hold_full_d = 1'b1;
			pend_full_d = 1'b0;
		end
		if (read_data_done && hold_full_q) begin
			// one cycle of byte available low before the next byte shows
			hold_full_d = 1'b0;
			xfer_d      = pend_full_q;                                   // see [RQ14]
		end
		if (ev_i.byte_done && !overflow) begin
			if (!hold_full_d && !xfer_d && !pend_full_d) begin
				hold_d      = rx_byte_i;
				hold_full_d = 1'b1;
			end else begin
				pend_d      = rx_byte_i;
				pend_full_d = 1'b1;
			end
		end
		if (any_err_set) begin
			// stale bytes are dropped with the message; last byte stays readable
			hold_full_d = 1'b0;                                          // see [RQ13]
			pend_full_d = 1'b0;
			xfer_d      = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_active_q <= 1'b0;
			hold_q      <= BRO_BYTE_RST;
			pend_q      <= BRO_BYTE_RST;
			hold_full_q <= 1'b0;
			pend_full_q <= 1'b0;
			xfer_q      <= 1'b0;
		end else begin
			rx_active_q <= rx_active_d;
			hold_q      <= hold_d;
			pend_q      <= pend_d;
			hold_full_q <= hold_full_d;
			pend_full_q <= pend_full_d;
			xfer_q      <= xfer_d;
		end
	end

	// ------------------------------------------------------------
	// output stage
	// ------------------------------------------------------------
	logic [7:0] dout_q, dout_d;
	logic [7:0] err_word;
	logic       oe_q, oe_d;
	logic       ser_data_q, ser_data_d;
	logic       ser_clk_q, ser_clk_d;

	always_comb begin
		err_word                = {err_q, BRO_SPARE_LEVEL};                 // see [RQ15]
		dout_d                  = pin.sel ? hold_q : err_word;              // see [RQ1] [RQ3]
		oe_d                    = pin.oe;                                   // see [RQ2]
		ser_data_d              = ser_bit_i;                                // see [RQ11]
		ser_clk_d               = ser_shift_i;                              // see [RQ11]
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dout_q     <= BRO_BYTE_RST;
			oe_q       <= 1'b0;
			ser_data_q <= 1'b0;
			ser_clk_q  <= 1'b0;
		end else begin
			dout_q     <= dout_d;
			oe_q       <= oe_d;
			ser_data_q <= ser_data_d;
			ser_clk_q  <= ser_clk_d;
		end
	end

	assign data_o       = dout_q;
	assign data_oe      = oe_q;                                          // see [RQ2]
	assign error_o      = |err_q;                                        // see [RQ13]
	assign rx_active_o  = rx_active_q;
	assign byte_avail_o = hold_full_q && !error_o;                       // see [RQ13]
	assign ser_data_o   = ser_data_q;
	assign ser_clk_o    = ser_clk_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence seq_err_read;
		read_err_done && !any_err_set;
	endsequence

	sequence seq_move_pending;
		read_data_done && hold_full_q && pend_full_q && !any_err_set && !ev_i.byte_done;
	endsequence

	chk_error_word_mux: assert property (  // see [RQ1]
		!pin.sel |=> data_o == {$past(err_q), 1'b0})
		else $error("error word not shown with select low");

	chk_data_byte_mux: assert property (  // see [RQ1]
		pin.sel |=> data_o == $past(hold_q))
		else $error("data byte not shown with select high");

	chk_bus_enable: assert property (  // see [RQ2]
		!pin.oe ##1 !pin.oe |-> !data_oe)
		else $error("bus driven while enable low");

	chk_overflow_flag: assert property (  // see [RQ4]
		overflow |=> err_q[BRO_ERR_OVERFLOW] && !rx_active_o)
		else $error("overflow not flagged");

	chk_parity_flag: assert property (  // see [RQ5]
		ev_i.parity_bad |=> err_q[BRO_ERR_PARITY] && err_q[BRO_ERR_SUMMARY])
		else $error("parity error not flagged");

	chk_summary_bit: assert property (  // see [RQ6]
		err_q[BRO_ERR_SUMMARY] == (err_q[BRO_ERR_PARITY] | err_q[BRO_ERR_BAD_END]
		                           | err_q[BRO_ERR_LOST_MID]))
		else $error("summary bit disagrees with causes");

	chk_bad_end_flag: assert property (  // see [RQ7]
		ev_i.end_bad |=> err_q[BRO_ERR_BAD_END] && err_q[BRO_ERR_SUMMARY])
		else $error("ending sequence error not flagged");

	chk_lost_mid_flag: assert property (  // see [RQ8]
		ev_i.mid_lost |=> err_q[BRO_ERR_LOST_MID] && err_q[BRO_ERR_SUMMARY])
		else $error("mid-bit loss not flagged");

	chk_restart_flag: assert property (  // see [RQ9]
		ev_i.start_ok && hold_full_q |=> err_q[BRO_ERR_RESTART] && error_o)
		else $error("restart over unread byte not flagged");

	chk_disable_flag: assert property (  // see [RQ10]
		pin.rx_dis && rx_active_q |=> err_q[BRO_ERR_DISABLED] && !rx_active_o)
		else $error("disable during message not flagged");

	chk_serial_copy: assert property (  // see [RQ11]
		ser_data_o == $past(ser_bit_i) && ser_clk_o == $past(ser_shift_i))
		else $error("serial copy lags wrongly");

	chk_error_clear: assert property (  // see [RQ12]
		seq_err_read |=> !error_o)
		else $error("error flag not cleared by error read");

	chk_error_ends_msg: assert property (  // see [RQ13]
		any_err_set |=> error_o && !rx_active_o && !byte_avail_o)
		else $error("error did not end message");

	chk_pending_move: assert property (  // see [RQ14]
		seq_move_pending |=> !byte_avail_o ##1 (byte_avail_o || error_o)
		                     && hold_q == $past(pend_q, 2))
		else $error("pending byte not moved after read");

	chk_spare_low: assert property (  // see [RQ15]
		!pin.sel |=> !data_o[BRO_ERR_SPARE])
		else $error("spare bit not low in error mode");

endmodule : bro_output_mux

// ==== core/bro_pkg.sv ====
package bro_pkg;

	// ------------------------------------------------------------
	// bus and error word layout
	// ------------------------------------------------------------
	localparam int          BRO_DATA_W       = 8;
	localparam int          BRO_ERR_SPARE    = 0;
	localparam int          BRO_ERR_OVERFLOW = 1;
	localparam int          BRO_ERR_PARITY   = 2;
	localparam int          BRO_ERR_SUMMARY  = 3;
	localparam int          BRO_ERR_BAD_END  = 4;
	localparam int          BRO_ERR_LOST_MID = 5;
	localparam int          BRO_ERR_RESTART  = 6;
	localparam int          BRO_ERR_DISABLED = 7;
	localparam logic        BRO_SPARE_LEVEL  = 1'b0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:1]  BRO_ERR_RST      = 7'h00;
	localparam logic [7:0]  BRO_BYTE_RST     = 8'h00;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	// host-side pins, all asynchronous to clock
	typedef struct packed {
		logic sel;      // high: data byte, low: error word
		logic oe;       // high: parallel bus driven
		logic read_n;   // low while the host reads
		logic rx_dis;   // high: receiver inputs disabled
	} bro_pins_t;

	localparam int          BRO_PIN_W        = $bits(bro_pins_t);
	localparam bro_pins_t   BRO_PINS_RST     = 4'h2;

	// one-cycle events from the demodulator, same clock
	typedef struct packed {
		logic start_ok;   // valid starting sequence seen
		logic end_ok;     // valid ending sequence seen
		logic byte_done;  // shift register holds a full byte
		logic parity_bad; // odd parity over data and sync
		logic end_bad;    // ending sequence malformed
		logic mid_lost;   // mid-bit transition missing
	} bro_ev_t;

endpackage : bro_pkg

// ==== verif/biphase_rx_output_error_mux_tb.sv ====
`timescale 1ns/1ps
module biphase_rx_output_error_mux_tb;
	import bro_pkg::*;
	logic       clock, rst_n, ser_bit_i, ser_shift_i;
	logic       data_oe, error_o, rx_active_o, byte_avail_o, ser_data_o, ser_clk_o;
	logic [7:0] rx_byte_i, data_o, bus, v;
	bro_pins_t  pins;
	bro_ev_t    ev_i;
	int         failures = 0;
	int         checked = 0;
	bro_ev_t    err_ev [3] = '{6'h04, 6'h02, 6'h01};
	logic [7:0] err_wd [3] = '{8'h0C, 8'h18, 8'h28};
	bro_output_mux bro_output_mux_i (.clock(clock), .rst_n(rst_n), .pins_i(pins),
		.ev_i(ev_i), .rx_byte_i(rx_byte_i), .ser_bit_i(ser_bit_i),
		.ser_shift_i(ser_shift_i), .data_o(data_o), .data_oe(data_oe),
		.error_o(error_o), .rx_active_o(rx_active_o), .byte_avail_o(byte_avail_o),
		.ser_data_o(ser_data_o), .ser_clk_o(ser_clk_o));
	bro_host_model bro_host_model_i (.clock(clock), .data_o(data_o), .data_oe(data_oe),
		.pins(pins), .bus(bus));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic pulse(input bro_ev_t e, input logic [7:0] b);
		@(posedge clock);
		ev_i      <= e;
		rx_byte_i <= b;
		@(posedge clock);
		ev_i <= '0;
		#1;
	endtask : pulse
	task automatic report_and_stop;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (5000) @(posedge clock);
		failures++;
		report_and_stop();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		ev_i = '0;
		rx_byte_i = 8'h00;
		ser_bit_i = 1'b0;
		ser_shift_i = 1'b0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		pulse(6'h20, 8'h00);
		pulse(6'h08, 8'hA5);
		pulse(6'h08, 8'h3C);
		chk("byte_avail", {7'h00, byte_avail_o}, 8'h01);
		bro_host_model_i.read_reg(1'b1, v);
		chk("data byte", v, 8'hA5);
		chk("byte_avail", {7'h00, byte_avail_o}, 8'h01);
		bro_host_model_i.read_reg(1'b1, v);
		chk("pending byte", v, 8'h3C);
		chk("byte_avail", {7'h00, byte_avail_o}, 8'h00);
		repeat (6) @(posedge clock);
		#1;
		chk("data_oe", {7'h00, data_oe}, 8'h00);
		$display("test data path done");
		for (int i = 0; i < 3; i++) begin
			pulse(6'h20, 8'h00);
			pulse(6'h08, 8'h11);
			pulse(err_ev[i], 8'h00);
			chk("error_o", {7'h00, error_o}, 8'h01);
			chk("active", {6'h00, rx_active_o, byte_avail_o}, 8'h00);
			bro_host_model_i.read_reg(1'b0, v);
			chk("error word", v, err_wd[i]);
			chk("error_o", {7'h00, error_o}, 8'h00);
		end
		$display("test error codes done");
		pulse(6'h20, 8'h00);
		repeat (3) pulse(6'h08, 8'h22);
		bro_host_model_i.read_reg(1'b0, v);
		chk("overflow word", v, 8'h02);
		pulse(6'h20, 8'h00);
		pulse(6'h08, 8'h33);
		pulse(6'h20, 8'h00);
		chk("error_o", {7'h00, error_o}, 8'h01);
		pulse(6'h20, 8'h00);
		chk("error_o", {7'h00, error_o}, 8'h00);
		pulse(6'h20, 8'h00);
		pulse(6'h08, 8'h44);
		pulse(6'h20, 8'h00);
		bro_host_model_i.read_reg(1'b0, v);
		chk("restart word", v, 8'h40);
		// a clean ending sequence closes the message; disabling then is no error
		pulse(6'h20, 8'h00);
		pulse(6'h10, 8'h00);
		chk("ended", {6'h00, rx_active_o, error_o}, 8'h00);
		bro_host_model_i.set_dis(1'b1);
		chk("idle disable", {7'h00, error_o}, 8'h00);
		bro_host_model_i.set_dis(1'b0);
		pulse(6'h20, 8'h00);
		chk("active", {7'h00, rx_active_o}, 8'h01);
		bro_host_model_i.set_dis(1'b1);
		bro_host_model_i.read_reg(1'b0, v);
		chk("disable word", v, 8'h80);
		bro_host_model_i.set_dis(1'b0);
		$display("test error sources done");
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			ser_bit_i   <= i[0];
			ser_shift_i <= ~i[1];
			@(posedge clock);
			#1;
			chk("serial copy", {6'h00, ser_data_o, ser_clk_o}, {6'h00, i[0], ~i[1]});
		end
		$display("test serial copy done");
		report_and_stop();
	end
endmodule : biphase_rx_output_error_mux_tb

// ==== verif/bro_host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// host reading the parallel bus
// ----------------------------------------
module bro_host_model (
	input  wire logic         clock,
	input  wire logic [7:0]   data_o,
	input  wire logic         data_oe,
	output bro_pkg::bro_pins_t pins,
	output logic      [7:0]   bus
);
	import bro_pkg::*;
	logic [7:0] last_q = 8'h00;
	// released bus shows the inverse, so a stale value never passes
	always @(posedge clock) if (data_oe) last_q <= data_o;
	assign bus = data_oe ? data_o : ~last_q;
	initial pins = BRO_PINS_RST;
	// select held from before strobe fall until well after its rise
	task automatic read_reg(input logic sel, output logic [7:0] val);
		@(posedge clock);
		pins.sel <= sel;
		pins.oe  <= 1'b1;
		repeat (6) @(posedge clock);
		val = bus;
		pins.read_n <= 1'b0;
		repeat (4) @(posedge clock);
		pins.read_n <= 1'b1;
		repeat (6) @(posedge clock);
		pins.oe <= 1'b0;
		// callers look at flags next; let this edge's updates land first
		#1;
	endtask : read_reg
	task automatic set_dis(input logic v);
		@(posedge clock);
		pins.rx_dis <= v;
		repeat (6) @(posedge clock);
	endtask : set_dis
endmodule : bro_host_model
